// >>> ccs_defines.svh
// Register offsets, field positions, reset values and timing for the channel
`ifndef CCS_DEFINES_SVH
`define CCS_DEFINES_SVH
`define CCS_OFS_CTRL0   5'h00
`define CCS_OFS_CTRL1   5'h04
`define CCS_OFS_TXBUF   5'h08
`define CCS_OFS_RXBUF   5'h0C
`define CCS_OFS_SMR4    5'h10
`define CCS_OFS_SIO3    5'h14
`define CCS_OFS_INT     5'h18
`define CCS_C0_INTCLK   0
`define CCS_C0_CLOCK_POLARITY_BIT    1
`define CCS_C0_CTSEN    2
`define CCS_C0_RTSEN    3
`define CCS_C0_CUTOFF   4
`define CCS_C0_DIV_LSB  8
`define CCS_C0_DIV_MSB  15
`define CCS_C1_TE       0
`define CCS_C1_TI       1
`define CCS_C1_RE       2
`define CCS_C1_RI       3
`define CCS_C1_IRS      4
`define CCS_C1_ERE      5
`define CCS_C1_SIM      6
`define CCS_RB_OER      12
`define CCS_S3_OUTDIS   0
`define CCS_S3_PINFN    1
`define CCS_S3_CLKINT   2
`define CCS_S3_DEFLVL   3
`define CCS_INT_RXIR    0
`define CCS_INT_TXIR    1
`define CCS_CTRL0_RST   16'h0300
`define CCS_SIO3_RST    4'h1
`define CCS_CLK_PERIOD_NS 4
`define CCS_SIO3_GLITCH_NS 10
`endif

// >>> ccs_pkg.sv
// Types shared by the clock synchronous channel
package ccs_pkg;
    typedef logic [7:0] ccs_byte_t;
    typedef enum logic [1:0]
    {
        CCS_IDLE   = 2'b00,
        CCS_SHIFT  = 2'b01,
        CCS_FINISH = 2'b11
    } ccs_state_e;
endpackage

// >>> ccs_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module ccs_sync #(parameter int W = 1)
(
    input  wire logic         core_clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_reg <= '0;
            q        <= '0;
        end
        else
        begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule // ccs_sync

// >>> ccs_sio3_pin.sv
// Third serial unit data pin: brief default level on pin-function switch while the clock is internal
`timescale 1ns/1ns
`include "ccs_defines.svh"
module ccs_sio3_pin
(
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic pin_function,
    input  wire logic out_disable,
    input  wire logic clock_internal,
    input  wire logic default_level,
    output logic      data_out,
    output logic      data_oe
);
    localparam int GLITCH_RAW = `CCS_SIO3_GLITCH_NS / `CCS_CLK_PERIOD_NS;
    localparam logic [3:0] GLITCH_CYC =
        (GLITCH_RAW < 1) ? 4'h1 : 4'(GLITCH_RAW);

    logic       fn_prev_reg;
    logic [3:0] cnt_reg;
    wire        trig = pin_function & ~fn_prev_reg & ~out_disable
                       & clock_internal;

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            fn_prev_reg <= 1'b0;
            cnt_reg     <= 4'h0;
            data_oe     <= 1'b0;
            data_out    <= 1'b0;
        end
        else
        begin
            fn_prev_reg <= pin_function;
            data_out    <= default_level;
            if (trig)
                cnt_reg <= GLITCH_CYC;
            else if (cnt_reg != 4'h0)
                cnt_reg <= cnt_reg - 4'h1;
            // Then held high impedance; disable wins at once
            data_oe <= ~out_disable & (trig | (cnt_reg > 4'h1));
        end
    end
endmodule // ccs_sio3_pin

// >>> ccs_channel.sv
// Clock synchronous serial channel with Avalon-MM register slave
//
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ns
`include "ccs_defines.svh"
module ccs_channel
(
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        serial_clock_in,
    output logic             serial_clock_out,
    output logic             serial_clock_oe,
    input  wire logic        serial_in,
    output logic             serial_out_pin,
    input  wire logic        clear_to_send_in,
    output logic             ready_to_send_out,
    output logic             ready_to_send_oe,
    input  wire logic        nonmaskable_in_n,
    output logic             sio3_data_out,
    output logic             sio3_data_oe
);
    function automatic logic idle_lvl(input logic pol);
        idle_lvl = ~pol;
    endfunction

    logic [15:0]        ctrl0_reg;
    logic               te_reg;
    logic               re_reg;
    logic               irs_reg;
    logic               ere_reg;
    logic               sim_reg;
    logic               tx_empty_reg;
    logic               rx_full_reg;
    logic               ovr_reg;
    ccs_pkg::ccs_byte_t txbuf_reg;
    ccs_pkg::ccs_byte_t rxbuf_reg;
    ccs_pkg::ccs_byte_t tx_sh_reg;
    ccs_pkg::ccs_byte_t rx_sh_reg;
    logic [3:0]         smr4_reg;
    logic [3:0]         sio3_reg;
    logic               rx_ir_reg;
    logic               tx_ir_reg;
    logic               sim_arm_reg;
    ccs_pkg::ccs_state_e state_reg;
    logic [2:0]         bit_cnt_reg;
    logic [7:0]         div_cnt_reg;
    logic               sclk_prev_reg;
    logic [3:0]         pins_s;

    ccs_sync #(.W(4)) u_sync
    (
        .core_clk (core_clk),
        .nrst     (nrst),
        .d        ({serial_clock_in, serial_in, clear_to_send_in,
                    nonmaskable_in_n}),
        .q        (pins_s)
    );

    ccs_sio3_pin u_sio3
    (
        .core_clk       (core_clk),
        .nrst           (nrst),
        .pin_function   (sio3_reg[`CCS_S3_PINFN]),
        .out_disable    (sio3_reg[`CCS_S3_OUTDIS]),
        .clock_internal (sio3_reg[`CCS_S3_CLKINT]),
        .default_level  (sio3_reg[`CCS_S3_DEFLVL]),
        .data_out       (sio3_data_out),
        .data_oe        (sio3_data_oe)
    );

    // Bus decode
    wire wr_go   = avs_write & ~avs_waitrequest;
    wire rd_go   = avs_read & avs_waitrequest;
    wire rd_done = avs_read & ~avs_waitrequest;
    wire wr_c0   = wr_go & (avs_address == `CCS_OFS_CTRL0);
    wire wr_c1   = wr_go & (avs_address == `CCS_OFS_CTRL1);
    wire wr_tx   = wr_go & (avs_address == `CCS_OFS_TXBUF);
    wire wr_smr4 = wr_go & (avs_address == `CCS_OFS_SMR4);
    wire wr_sio3 = wr_go & (avs_address == `CCS_OFS_SIO3);
    wire wr_int  = wr_go & (avs_address == `CCS_OFS_INT);
    wire rd_rx   = rd_done & (avs_address == `CCS_OFS_RXBUF);
    wire [7:0] wd = avs_writedata[7:0];

    // Mode decode
    wire       sclk_s  = pins_s[3];
    wire       sin_s   = pins_s[2];
    wire       cts_s   = pins_s[1];
    wire       nmi_s   = pins_s[0];
    wire       intclk  = ctrl0_reg[`CCS_C0_INTCLK];
    wire       pol     = ctrl0_reg[`CCS_C0_CLOCK_POLARITY_BIT];
    wire [7:0] div     = ctrl0_reg[`CCS_C0_DIV_MSB:`CCS_C0_DIV_LSB];
    wire       idle    = state_reg == ccs_pkg::CCS_IDLE;
    wire       active  = state_reg == ccs_pkg::CCS_SHIFT;
    wire       cut     = ctrl0_reg[`CCS_C0_CUTOFF] & ~nmi_s;
    wire       cts_ok  = ~ctrl0_reg[`CCS_C0_CTSEN] | ~cts_s;
    wire       clk_idle = intclk | (sclk_s == idle_lvl(pol));
    // Receive rides on the transmit start, so its enables gate it too
    wire       start   = idle & te_reg & ~tx_empty_reg & cts_ok
                         & clk_idle;
    wire       tick    = active & (div_cnt_reg == 8'h00);

    // Leading edge shifts out, trailing edge samples
    wire rise  = sclk_s & ~sclk_prev_reg;
    wire fall  = ~sclk_s & sclk_prev_reg;
    wire i_lead  = tick & (serial_clock_out == idle_lvl(pol));
    wire i_trail = tick & (serial_clock_out != idle_lvl(pol));
    wire e_lead  = active & (pol ? rise : fall);
    wire e_trail = active & (pol ? fall : rise);
    wire lead    = intclk ? i_lead : e_lead;
    wire trail   = intclk ? i_trail : e_trail;
    wire last    = trail & (bit_cnt_reg == 3'h7);
    wire [7:0] rx_word = {sin_s, rx_sh_reg[7:1]};
    wire rx_land = last & re_reg;
    wire overrun = rx_land & rx_full_reg & ~rd_rx;
    wire sim_lvl = sim_reg & irs_reg & ere_reg;
    wire tx_ev   = (irs_reg ? last : start)
                   | (sim_lvl & ~sim_arm_reg);
    // Ready stands until the peer's first clock edge arrives
    wire rts_rdy = re_reg & te_reg
                   & ((idle & ~tx_empty_reg)
                      | (active & (bit_cnt_reg == 3'h0) & clk_idle));

    wire [31:0] rd_mux =
        (avs_address == `CCS_OFS_CTRL0) ? {16'h0000, ctrl0_reg} :
        (avs_address == `CCS_OFS_CTRL1) ?
            {25'h0000000, sim_reg, ere_reg, irs_reg, rx_full_reg,
             re_reg, tx_empty_reg, te_reg} :
        (avs_address == `CCS_OFS_TXBUF) ? {24'h000000, txbuf_reg} :
        (avs_address == `CCS_OFS_RXBUF) ?
            {19'h00000, ovr_reg, 4'h0, rxbuf_reg} :
        (avs_address == `CCS_OFS_SMR4)  ? {28'h0000000, smr4_reg} :
        (avs_address == `CCS_OFS_SIO3)  ? {28'h0000000, sio3_reg} :
        (avs_address == `CCS_OFS_INT)   ?
            {30'h00000000, tx_ir_reg, rx_ir_reg} : 32'h00000000;

    // One wait cycle per access; unmapped reads give zero
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end
        else
        begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
            if (rd_go)
                avs_readdata <= rd_mux;
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl0_reg <= `CCS_CTRL0_RST;
            te_reg    <= 1'b0;
            re_reg    <= 1'b0;
            irs_reg   <= 1'b0;
            ere_reg   <= 1'b0;
            sim_reg   <= 1'b0;
            smr4_reg  <= 4'h0;
            sio3_reg  <= `CCS_SIO3_RST;
            txbuf_reg <= 8'h00;
        end
        else
        begin
            if (wr_c0)
                ctrl0_reg <= avs_writedata[15:0];
            if (wr_c1)
            begin
                te_reg  <= wd[`CCS_C1_TE];
                re_reg  <= wd[`CCS_C1_RE];
                irs_reg <= wd[`CCS_C1_IRS];
                ere_reg <= wd[`CCS_C1_ERE];
                sim_reg <= wd[`CCS_C1_SIM];
            end
            if (wr_smr4)
                smr4_reg <= wd[3:0];
            if (wr_sio3)
                sio3_reg <= wd[3:0];
            if (wr_tx)
                txbuf_reg <= wd;
        end
    end

    // Status flags: hardware set wins over software clear, except tx_empty_reg, where a TXBUF write wins over the start
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tx_empty_reg <= 1'b1;
            rx_full_reg  <= 1'b0;
            ovr_reg      <= 1'b0;
            rxbuf_reg    <= 8'h00;
            rx_ir_reg    <= 1'b0;
            tx_ir_reg    <= 1'b0;
            sim_arm_reg  <= 1'b0;
        end
        else
        begin
            sim_arm_reg <= sim_lvl;
            // A write in the load cycle keeps the new word pending
            if (wr_tx)
                tx_empty_reg <= 1'b0;
            else if (start)
                tx_empty_reg <= 1'b1;
            if (rx_land)
                rxbuf_reg <= rx_word;
            if (rx_land)
                rx_full_reg <= 1'b1;
            else if (rd_rx)
                rx_full_reg <= 1'b0;
            if (overrun)
                ovr_reg <= 1'b1;
            else if (!re_reg)
                ovr_reg <= 1'b0;
            if (rx_land & ~overrun)
                rx_ir_reg <= 1'b1;
            else if (wr_int & ~wd[`CCS_INT_RXIR])
                rx_ir_reg <= 1'b0;
            if (tx_ev)
                tx_ir_reg <= 1'b1;
            else if (wr_int & ~wd[`CCS_INT_TXIR])
                tx_ir_reg <= 1'b0;
        end
    end

    // Shift engine
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg   <= ccs_pkg::CCS_IDLE;
            bit_cnt_reg <= 3'h0;
            tx_sh_reg   <= 8'h00;
            rx_sh_reg   <= 8'h00;
            serial_out_pin <= 1'b1;
        end
        else
        begin
            case (state_reg)
                ccs_pkg::CCS_IDLE:
                begin
                    bit_cnt_reg <= 3'h0;
                    if (start)
                    begin
                        tx_sh_reg <= txbuf_reg;
                        state_reg <= ccs_pkg::CCS_SHIFT;
                    end
                end
                ccs_pkg::CCS_SHIFT:
                begin
                    if (lead)
                    begin
                        serial_out_pin <= tx_sh_reg[0];
                        tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
                    end
                    if (trail)
                    begin
                        rx_sh_reg   <= rx_word;
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                    end
                    if (last)
                        state_reg <= ccs_pkg::CCS_FINISH;
                end
                ccs_pkg::CCS_FINISH:
                    state_reg <= ccs_pkg::CCS_IDLE;
                default:
                    state_reg <= ccs_pkg::CCS_IDLE;
            endcase
        end
    end

    // Internal clock generator and pin drivers
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            div_cnt_reg       <= 8'h00;
            serial_clock_out  <= 1'b1;
            sclk_prev_reg     <= 1'b0;
            serial_clock_oe   <= 1'b0;
            ready_to_send_out <= 1'b1;
            ready_to_send_oe  <= 1'b0;
        end
        else
        begin
            sclk_prev_reg <= sclk_s;
            if (!active || tick)
                div_cnt_reg <= div;
            else
                div_cnt_reg <= div_cnt_reg - 8'h01;
            if (!active)
                serial_clock_out <= idle_lvl(pol);
            else if (tick)
                serial_clock_out <= ~serial_clock_out;
            serial_clock_oe  <= intclk & ~cut;
            ready_to_send_oe <= ~cut;
            // Internal clock leaves the pin inactive high
            if (!intclk && ctrl0_reg[`CCS_C0_RTSEN])
                ready_to_send_out <= ~rts_rdy;
            else
                ready_to_send_out <= 1'b1;
        end
    end
endmodule // ccs_channel

// >>> ccs_peer.sv
// Behavioural model of the clock synchronous serial peer
`timescale 1ns/1ns
module ccs_peer
(
    input  wire logic clk_pin,
    input  wire logic clk_oe,
    input  wire logic pol,
    input  wire logic dout,
    output logic      sclk,
    output logic      din,
    output logic      cts_n
);
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    int         nbits;

    initial
    begin
        sclk  = 1'b1;
        din   = 1'b1;
        cts_n = 1'b0;
        nbits = 8;
    end

    task load(input logic [7:0] b);
        tx_q  = b;
        nbits = 0;
    endtask

    // Device clock: drive on leading edge, capture on trailing edge
    always @(clk_pin)
    begin
        if (clk_oe && nbits < 8)
        begin
            if (clk_pin == pol)
                din = tx_q[nbits];
            else
            begin
                rx_q[nbits] = dout;
                nbits++;
                // Released line shows inverse, not last value
                if (nbits == 8)
                    din = ~din;
            end
        end
    end

    // Own clock; idles at the inverse of the polarity level, still between frames
    task ext(input logic [7:0] b);
        tx_q  = b;
        nbits = 0;
        // Off the core clock edges, as a free running peer would be
        #1;
        repeat (8)
        begin
            sclk = pol;
            din  = tx_q[nbits];
            #80;
            sclk = ~pol;
            rx_q[nbits] = dout;
            nbits++;
            #80;
        end
        din = ~din;
    endtask
endmodule // ccs_peer

// >>> ccs_channel_asserts.sv
// Port level assertions for the serial channel
`timescale 1ns/1ns
`include "ccs_defines.svh"
module ccs_channel_asserts
(
    input wire logic        core_clk,
    input wire logic        nrst,
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        serial_clock_out,
    input wire logic        serial_clock_oe,
    input wire logic        serial_out_pin,
    input wire logic        ready_to_send_out,
    input wire logic        ready_to_send_oe,
    input wire logic        nonmaskable_in_n,
    input wire logic        sio3_data_out,
    input wire logic        sio3_data_oe
);
    logic [4:0] c0_q;
    logic [3:0] s3_q;
    wire        acc = avs_write && !avs_waitrequest;

    // Shadow copies of written control bits
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            c0_q <= 5'h00;
            s3_q <= `CCS_SIO3_RST;
        end
        else
        begin
            if (acc && avs_address == `CCS_OFS_CTRL0)
                c0_q <= avs_writedata[4:0];
            if (acc && avs_address == `CCS_OFS_SIO3)
                s3_q <= avs_writedata[3:0];
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("waitrequest late");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest &&
        avs_address == 5'h1C |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_rts_internal: assert property (serial_clock_oe |-> ready_to_send_out)
        else $error("ready active with internal clock");
    a_cutoff_float: assert property (c0_q[4] && !nonmaskable_in_n [*4]
        |-> !ready_to_send_oe && !serial_clock_oe) else $error("no cutoff");
    a_lead_edge: assert property (serial_clock_oe && $changed(serial_out_pin)
        |-> serial_clock_out == c0_q[1]) else $error("data on wrong edge");
    a_sio3_pulse: assert property ($rose(sio3_data_oe)
        |-> sio3_data_oe [*2] ##1 !sio3_data_oe) else $error("pulse width");
    a_sio3_cause: assert property ($rose(sio3_data_oe)
        |-> s3_q[1] && !s3_q[0] && s3_q[2]) else $error("pulse cause");
    a_sio3_level: assert property (sio3_data_oe |-> sio3_data_out == s3_q[3])
        else $error("pulse level");

    c_sio3: cover property ($rose(sio3_data_oe));
    c_cutoff: cover property ($fell(ready_to_send_oe));
    c_int_clk: cover property (serial_clock_oe && $changed(serial_clock_out));
endmodule // ccs_channel_asserts

bind ccs_channel ccs_channel_asserts u_chk (.core_clk(core_clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .serial_clock_out(serial_clock_out),
    .serial_clock_oe(serial_clock_oe), .serial_out_pin(serial_out_pin),
    .ready_to_send_out(ready_to_send_out),
    .ready_to_send_oe(ready_to_send_oe), .nonmaskable_in_n(nonmaskable_in_n),
    .sio3_data_out(sio3_data_out), .sio3_data_oe(sio3_data_oe));

// >>> ccs_channel_test.sv
// Self-checking testbench for the serial channel
`timescale 1ns/1ns
module ccs_channel_test;
    logic        core_clk, nrst, avs_read, avs_write, avs_waitrequest;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q_e[$], q_m[$], e, m;
    logic        serial_clock_out, serial_clock_oe, serial_out_pin;
    logic        ready_to_send_out, ready_to_send_oe, nmi_n;
    logic        sio3_data_out, sio3_data_oe, sclk, din, cts_n, pol;
    logic [7:0]  tx, rx;
    int          err_total, num_checks, oe_cnt, n, i;
    int          seed = 32'h457c5934;
    // Shared clock pin: whoever has the enable sets the level
    wire clk_pin = serial_clock_oe ? serial_clock_out : sclk;

    ccs_channel u_dut (.core_clk(core_clk), .nrst(nrst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .serial_clock_in(clk_pin), .serial_clock_out(serial_clock_out),
        .serial_clock_oe(serial_clock_oe), .serial_in(din),
        .serial_out_pin(serial_out_pin), .clear_to_send_in(cts_n),
        .ready_to_send_out(ready_to_send_out),
        .ready_to_send_oe(ready_to_send_oe), .nonmaskable_in_n(nmi_n),
        .sio3_data_out(sio3_data_out), .sio3_data_oe(sio3_data_oe));
    ccs_peer u_peer (.clk_pin(clk_pin), .clk_oe(serial_clock_oe),
        .pol(pol), .dout(serial_out_pin), .sclk(sclk), .din(din),
        .cts_n(cts_n));

    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task complete_run;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
        num_checks++;
        if (sn !== ex)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, ex, sn);
        end
    endtask

    // Request held until waitrequest is seen low at a rising edge
    task bus(input logic [4:0] a, input logic r, input logic [31:0] d);
        @(posedge core_clk);
        avs_address   <= a;
        avs_read      <= r;
        avs_write     <= !r;
        avs_writedata <= d;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50)
        begin
            err_total++;
            complete_run();
        end
    endtask

    task wr(input logic [4:0] a, input logic [31:0] d);
        bus(a, 1'b0, d);
    endtask

    task rd(input logic [4:0] a, input logic [31:0] ex, input logic [31:0] mk);
        q_e.push_back(ex);
        q_m.push_back(mk);
        bus(a, 1'b1, 32'h0);
    endtask

    // Frame end seen at the peer, plus settle for sync and word transfer
    task wait_frame;
        n = 0;
        while (u_peer.nbits < 8 && n < 2000)
        begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 2000)
        begin
            err_total++;
            complete_run();
        end
        repeat (12) @(posedge core_clk);
    endtask

    always @(posedge core_clk)
    begin
        if (sio3_data_oe === 1'b1)
            oe_cnt <= oe_cnt + 1;
        if (avs_read && !avs_waitrequest)
        begin
            e = q_e.pop_front();
            m = q_m.pop_front();
            chk("readdata", e & m, avs_readdata & m);
        end
    end

    initial
    begin
        {nrst, avs_read, avs_write, pol, oe_cnt} = '0;
        {avs_address, avs_writedata} = '0;
        nmi_n = 1'b1;
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        rd(5'h00, 32'h0300, 32'hFFFF);
        rd(5'h04, 32'h2, 32'h7F);
        rd(5'h14, 32'h1, 32'hF);
        rd(5'h1C, 32'h0, 32'hFFFFFFFF);
        for (i = 0; i < 2; i++)
        begin
            pol = i[0];
            wr(5'h00, 32'h0701 | (i << 1));
            wr(5'h04, 32'h5);
            wr(5'h18, 32'h0);
            tx = $random(seed);
            rx = $random(seed);
            u_peer.load(rx);
            wr(5'h08, {24'h0, tx});
            wait_frame();
            chk("rts_internal", 1'b1, ready_to_send_out);
            rd(5'h04, 32'h8, 32'h8);
            rd(5'h18, 32'h1, 32'h1);
            rd(5'h0C, rx, 32'h10FF);
            chk("peer_rx", tx, u_peer.rx_q);
            rd(5'h04, 32'h0, 32'h8);
        end
        // Overrun: second word completes while first is unread
        u_peer.load($random(seed));
        wr(5'h08, 32'h5A);
        wait_frame();
        wr(5'h18, 32'h0);
        u_peer.load($random(seed));
        wr(5'h08, 32'hA5);
        wait_frame();
        rd(5'h18, 32'h0, 32'h1);
        rd(5'h0C, 32'h1000, 32'h1000);
        // External clock with ready-to-send
        pol = 1'b0;
        wr(5'h04, 32'h0);
        wr(5'h00, 32'h0708);
        wr(5'h04, 32'h5);
        tx = $random(seed);
        rx = $random(seed);
        wr(5'h08, {24'h0, tx});
        repeat (8) @(posedge core_clk);
        chk("rts_ready", 1'b0, ready_to_send_out);
        u_peer.ext(rx);
        repeat (12) @(posedge core_clk);
        chk("rts_started", 1'b1, ready_to_send_out);
        rd(5'h0C, rx, 32'h10FF);
        chk("peer_dummy", tx, u_peer.rx_q);
        // Transmitter off: peer clocks must not start a reception
        wr(5'h04, 32'h4);
        wr(5'h08, 32'h33);
        u_peer.ext($random(seed));
        repeat (12) @(posedge core_clk);
        rd(5'h04, 32'h0, 32'h8);
        // Clear-to-send held high must block the start
        u_peer.cts_n <= 1'b1;
        wr(5'h00, 32'h070C);
        wr(5'h04, 32'h5);
        repeat (8) @(posedge core_clk);
        rd(5'h04, 32'h0, 32'h2);
        u_peer.cts_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        rd(5'h04, 32'h2, 32'h2);
        rx = $random(seed);
        u_peer.ext(rx);
        repeat (12) @(posedge core_clk);
        rd(5'h0C, rx, 32'h10FF);
        chk("peer_cts", 32'h33, u_peer.rx_q);
        wr(5'h00, 32'h0718);
        nmi_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        chk("rts_oe_cut", 1'b0, ready_to_send_oe);
        nmi_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        chk("rts_oe_back", 1'b1, ready_to_send_oe);
        wr(5'h14, 32'h8);
        wr(5'h14, 32'hE);
        repeat (8) @(posedge core_clk);
        chk("sio3_pulse", 32'd2, oe_cnt);
        chk("sio3_level", 1'b1, sio3_data_out);
        wr(5'h18, 32'h0);
        wr(5'h04, 32'h70);
        repeat (2) @(posedge core_clk);
        rd(5'h18, 32'h2, 32'h2);
        wr(5'h18, 32'h0);
        rd(5'h18, 32'h0, 32'h2);
        wr(5'h10, 32'h0);
        wr(5'h10, 32'h1);
        rd(5'h10, 32'h1, 32'hF);
        complete_run();
    end
endmodule // ccs_channel_test
